// [fcs_pkg.sv]
package fcs_pkg;
  localparam int FCS_IDX_CONTROL = 0;
  localparam int FCS_IDX_CONFIG = 1;
  localparam int FCS_IDX_STATUS = 2;
  localparam logic [11:0] FCS_OFF_CONTROL = 12'(4 * FCS_IDX_CONTROL);
  localparam logic [11:0] FCS_OFF_CONFIG = 12'(4 * FCS_IDX_CONFIG);
  localparam logic [11:0] FCS_OFF_STATUS = 12'(4 * FCS_IDX_STATUS);
  localparam logic [11:0] FCS_OFF_FLASH_WORDS = 12'h00C;
  localparam logic [11:0] FCS_OFF_BOOT_APP_WORDS = 12'h010;
  localparam logic [11:0] FCS_OFF_BOOT_WORDS = 12'h014;
  localparam logic [11:0] FCS_OFF_BOOTCFG = 12'h018;
  localparam int FCS_BIT_ENABLE = 0;
  localparam int FCS_BIT_FAIL_IE = 1;
  localparam int FCS_BIT_SELF_RESET = 7;
  localparam int FCS_BIT_BUSY = 0;
  localparam int FCS_BIT_PASS = 1;
  localparam int FCS_MODE_LSB = 4;
  localparam int FCS_SECT_LSB = 0;
  localparam logic [7:0] FCS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FCS_CONFIG_RESET = 8'h00;
  localparam logic [7:0] FCS_STATUS_RESET = 8'h02;
  localparam logic [1:0] FCS_MODE_PRIORITY = 2'h0;
  localparam logic [1:0] FCS_MODE_SINGLE_BG = 2'h2;
  localparam logic [1:0] FCS_MODE_REPEAT_BG = 2'h3;
  localparam logic [1:0] FCS_SECT_FLASH = 2'h0;
  localparam logic [1:0] FCS_SECT_BOOT_APP = 2'h1;
  localparam logic [1:0] FCS_SECT_BOOT = 2'h2;
  localparam int FCS_START_DELAY_CYCLES = 3;
  localparam int FCS_FETCH_SPACING_CYCLES = 3;
  localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
  localparam logic [15:0] FCS_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] FCS_CRC_RESIDUE = 16'h0000;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] section;
  } fcs_setup_t;
  typedef enum logic [3:0] {
    FCS_IDLE = 4'h1,
    FCS_WAIT = 4'h2,
    FCS_FETCH = 4'h4,
    FCS_CHECK = 4'h8
  } fcs_state_t;
endpackage

// [fcs_scan_control.sv]
`timescale 1ns/1ps
module fcs_scan_control #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_scan_req,
  input wire fcs_pkg::fcs_setup_t boot_scan_setup,
  output logic cpu_stall,
  output logic flash_req,
  output logic flash_low_prio,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_gnt,
  input wire logic [15:0] flash_rdata,
  output logic fail_nmi
);
  import fcs_pkg::*;

  localparam logic [1:0] START_CNT = 2'(FCS_START_DELAY_CYCLES - 1);
  localparam logic [1:0] SPACE_CNT = 2'(FCS_FETCH_SPACING_CYCLES - 1);
  localparam int SEL_CTRL = 0;
  localparam int SEL_CFG = 1;
  localparam int SEL_STAT = 2;
  localparam int SEL_FLASH = 3;
  localparam int SEL_BOOT_APP = 4;
  localparam int SEL_BOOT = 5;

  logic enable;
  logic fail_ie;
  fcs_setup_t setup;
  logic busy;
  logic pass;
  logic self_rst_pend;
  logic boot_sync1;
  logic boot_sync2;
  logic boot_seen;
  logic startup_scan;
  logic [ADDR_W-1:0] flash_words;
  logic [ADDR_W-1:0] boot_app_words;
  logic [ADDR_W-1:0] boot_words;
  logic [ADDR_W-1:0] last_addr;
  logic [1:0] gap_cnt;
  logic [15:0] crc;
  fcs_state_t state;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ FCS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic setup_legal(input fcs_setup_t s);
    return (s.mode != 2'h1) && (s.section != 2'h3);
  endfunction

  // Shared by the error flag and every write strobe; the read mux decodes paddr itself
  function automatic logic [5:0] reg_select(input logic [11:0] a);
    logic [5:0] s;
    s = 6'h00;
    unique case (a)
      FCS_OFF_CONTROL: s[SEL_CTRL] = 1'b1;
      FCS_OFF_CONFIG: s[SEL_CFG] = 1'b1;
      FCS_OFF_STATUS: s[SEL_STAT] = 1'b1;
      FCS_OFF_FLASH_WORDS: s[SEL_FLASH] = 1'b1;
      FCS_OFF_BOOT_APP_WORDS: s[SEL_BOOT_APP] = 1'b1;
      FCS_OFF_BOOT_WORDS: s[SEL_BOOT] = 1'b1;
      default: s = 6'h00;
    endcase
    return s;
  endfunction

  logic wr_acc;
  logic nmi_fired;
  logic ctrl_wr;
  logic cfg_wr;
  logic self_rst_req;
  logic start_req;
  logic pass_done;
  logic fail_done;
  logic repeat_go;
  logic boot_rise;
  logic launch;
  logic [5:0] sel;

  assign wr_acc = psel && penable && pwrite && clk_en;
  assign nmi_fired = fail_nmi;
  assign sel = reg_select(paddr);
  assign ctrl_wr = wr_acc && sel[SEL_CTRL] && !nmi_fired;
  assign cfg_wr = wr_acc && sel[SEL_CFG] && !busy && !nmi_fired;
  assign self_rst_req = ctrl_wr && pwdata[FCS_BIT_SELF_RESET]
                        && (!fail_ie || !busy);
  assign start_req = ctrl_wr && pwdata[FCS_BIT_ENABLE] && !self_rst_req;
  assign pass_done = state == FCS_CHECK && crc == FCS_CRC_RESIDUE;
  assign fail_done = state == FCS_CHECK && crc != FCS_CRC_RESIDUE;
  assign repeat_go = pass_done && enable && setup.mode == FCS_MODE_REPEAT_BG;
  assign boot_rise = boot_sync2 && !boot_seen;
  // Reserved settings never launch from software; a startup request launches whatever its section
  assign launch = (start_req && setup_legal(setup)) || boot_rise;

  always_comb begin
    unique case (setup.section)
      FCS_SECT_BOOT_APP: last_addr = boot_app_words - ADDR_W'(1);
      FCS_SECT_BOOT: last_addr = boot_words - ADDR_W'(1);
      default: last_addr = flash_words - ADDR_W'(1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Zero-wait slave: the answer always lands in the first access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && sel == 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (clk_en) begin
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          FCS_OFF_CONTROL: prdata <= {30'h0, fail_ie, enable};
          FCS_OFF_CONFIG: prdata <= {26'h0, setup.mode, 2'h0, setup.section};
          FCS_OFF_STATUS: prdata <= {30'h0, pass && !busy, busy};
          FCS_OFF_FLASH_WORDS: prdata <= 32'(flash_words);
          FCS_OFF_BOOT_APP_WORDS: prdata <= 32'(boot_app_words);
          FCS_OFF_BOOT_WORDS: prdata <= 32'(boot_words);
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Section sizes stand in for fuses; locked while busy so the end stays put
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_words <= '1;
      boot_app_words <= '1;
      boot_words <= '1;
    end else if (wr_acc && !busy) begin
      if (sel[SEL_FLASH]) flash_words <= pwdata[ADDR_W-1:0];
      if (sel[SEL_BOOT_APP]) boot_app_words <= pwdata[ADDR_W-1:0];
      if (sel[SEL_BOOT]) boot_words <= pwdata[ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup scan request from the reset sequencer

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_sync1 <= 1'b0;
      boot_sync2 <= 1'b0;
      boot_seen <= 1'b0;
    end else if (clk_en) begin
      boot_sync1 <= boot_scan_req;
      boot_sync2 <= boot_sync1;
      boot_seen <= boot_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and config registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      self_rst_pend <= 1'b0;
    end else if (clk_en) begin
      self_rst_pend <= self_rst_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_ie <= 1'b0;
    end else if (clk_en && ctrl_wr && pwdata[FCS_BIT_FAIL_IE] && !busy) begin
      fail_ie <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable <= FCS_CONTROL_RESET[FCS_BIT_ENABLE];
      setup <= fcs_fcs_cfg(FCS_CONFIG_RESET);
    end else if (clk_en) begin
      if (self_rst_pend) begin
        enable <= 1'b0;
        setup <= fcs_fcs_cfg(FCS_CONFIG_RESET);
      end else if (boot_sync2 && !boot_seen) begin
        enable <= 1'b1;
        setup <= '{mode: FCS_MODE_SINGLE_BG, section: boot_scan_setup.section};
      end else begin
        if (ctrl_wr && !self_rst_req) enable <= pwdata[FCS_BIT_ENABLE];
        if (cfg_wr) begin
          setup.mode <= pwdata[FCS_MODE_LSB+:2];
          setup.section <= pwdata[FCS_SECT_LSB+:2];
        end
        if (fail_done) enable <= 1'b0;
      end
    end
  end

  function automatic fcs_setup_t fcs_fcs_cfg(input logic [7:0] v);
    return '{mode: v[FCS_MODE_LSB+:2], section: v[FCS_SECT_LSB+:2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scan status

  // Self-reset wins over a pass that ends in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= FCS_STATUS_RESET[FCS_BIT_BUSY];
      pass <= FCS_STATUS_RESET[FCS_BIT_PASS];
    end else if (clk_en) begin
      if (self_rst_pend) begin
        busy <= FCS_STATUS_RESET[FCS_BIT_BUSY];
        pass <= 1'b0;
      end else if (state == FCS_IDLE && launch) begin
        busy <= 1'b1;
        pass <= 1'b0;
      end else if (state == FCS_IDLE && start_req) begin
        pass <= 1'b0;
      end else if (state == FCS_CHECK && !repeat_go) begin
        busy <= 1'b0;
        pass <= pass_done;
      end
    end
  end

  // Startup launches keep normal fetch priority even in background mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startup_scan <= 1'b0;
    end else if (clk_en && state == FCS_IDLE && launch) begin
      startup_scan <= boot_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= FCS_IDLE;
      gap_cnt <= 2'h0;
      crc <= FCS_CRC_INIT;
      flash_addr <= '0;
      flash_req <= 1'b0;
      flash_low_prio <= 1'b0;
      cpu_stall <= 1'b0;
    end else if (clk_en) begin
      if (self_rst_pend) begin
        state <= FCS_IDLE;
        flash_req <= 1'b0;
        cpu_stall <= 1'b0;
      end else begin
        unique case (state)
          FCS_IDLE: begin
            if (launch) begin
              state <= FCS_WAIT;
              gap_cnt <= START_CNT;
            end
          end
          FCS_WAIT: begin
            if (gap_cnt == 2'h0) begin
              state <= FCS_FETCH;
              crc <= FCS_CRC_INIT;
              flash_addr <= '0;
              flash_req <= 1'b1;
              flash_low_prio <= setup.mode != FCS_MODE_PRIORITY && !startup_scan;
              cpu_stall <= setup.mode == FCS_MODE_PRIORITY;
            end else begin
              gap_cnt <= gap_cnt - 2'h1;
            end
          end
          FCS_FETCH: begin
            if (gap_cnt != 2'h0) begin
              gap_cnt <= gap_cnt - 2'h1;
            end else if (flash_req && flash_gnt) begin
              crc <= crc_word(crc, flash_rdata);
              flash_req <= 1'b0;
              gap_cnt <= SPACE_CNT;
              if (flash_addr == last_addr) begin
                state <= FCS_CHECK;
              end else begin
                flash_addr <= flash_addr + ADDR_W'(1);
              end
            end else begin
              flash_req <= 1'b1;
            end
          end
          FCS_CHECK: begin
            cpu_stall <= 1'b0;
            if (repeat_go) begin
              state <= FCS_WAIT;
              gap_cnt <= 2'h0;
            end else begin
              state <= FCS_IDLE;
            end
          end
          default: state <= FCS_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure interrupt, held until system reset

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_nmi <= 1'b0;
    end else if (clk_en && fail_done && fail_ie) begin
      fail_nmi <= 1'b1;
    end
  end

endmodule // fcs_scan_control

// [fcs_scan_control_assertions.sv]
`timescale 1ns/1ps
module fcs_scan_control_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic cpu_stall,
  input wire logic flash_req,
  input wire logic flash_low_prio,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_gnt,
  input wire logic fail_nmi
);
  import fcs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic en_wr;
  // Plain enable writes only; the bench rewrites other values mid-scan
  assign en_wr = psel && penable && pwrite && paddr == FCS_OFF_CONTROL
    && pwdata[1:0] == 2'b01 && !flash_req;
  ////////////////////////////////
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  hi_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  nmi_hold_a: assert property (fail_nmi |=> fail_nmi)
    else $error("interrupt dropped");
  // Self-reset may cut a pending fetch, so recent accesses are excluded
  req_hold_a: assert property (flash_req && !flash_gnt && !pready && !$past(pready)
    |=> flash_req && $stable(flash_addr)) else $error("fetch request not held");
  fetch_gap_a: assert property (flash_req && flash_gnt |=> !flash_req [*2])
    else $error("fetches too close");
  start_wait_a: assert property (en_wr |=> !flash_req [*3])
    else $error("scan started early");
  stall_hold_a: assert property (cpu_stall && flash_req && !flash_gnt |=> cpu_stall)
    else $error("stall released mid fetch");
  bg_free_a: assert property (flash_low_prio |-> !cpu_stall)
    else $error("background scan stalls");
  cover property (flash_gnt && cpu_stall);
  cover property (flash_gnt && flash_low_prio);
  cover property ($rose(fail_nmi));
endmodule // fcs_scan_control_assertions

// [fcs_flash_model.sv]
`timescale 1ns/1ps
module fcs_flash_model (
  input wire logic clk,
  input wire logic flash_req,
  input wire logic [15:0] flash_addr,
  output logic flash_gnt,
  output logic [15:0] flash_rdata
);
  logic [15:0] mem [16];
  // Random grant mixes prompt and slow answers
  always_ff @(posedge clk) begin
    flash_gnt <= flash_req && !flash_gnt && 1'($urandom);
  end
  // Inverted data off grant, so a word taken early never matches
  assign flash_rdata = flash_gnt ? mem[flash_addr[3:0]] : ~mem[flash_addr[3:0]];
endmodule // fcs_flash_model

// [fcs_scan_control_tb.sv]
`timescale 1ns/1ps
module fcs_scan_control_tb;
  import fcs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic boot_scan_req = 1'b0, pready, pslverr, cpu_stall, flash_req, flash_low_prio;
  logic flash_gnt, fail_nmi;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [15:0] flash_addr, flash_rdata;
  fcs_setup_t boot_scan_setup = '0;
  logic [33:0] exq [$];
  logic [33:0] nt;
  logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
  int fail_count = 0, total_checks = 0;
  int stall_cyc = 0, low_cyc = 0;
  fcs_scan_control #(.ADDR_W(16)) fcs_scan_control_i (.clk, .rst_n, .clk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_scan_req,
    .boot_scan_setup, .cpu_stall, .flash_req, .flash_low_prio, .flash_addr, .flash_gnt,
    .flash_rdata, .fail_nmi);
  fcs_flash_model fcs_flash_model_i (.clk, .flash_req, .flash_addr, .flash_gnt, .flash_rdata);
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////
  task chk(input logic [32:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Note bit 33 marks a checked read, bit 32 the expected error flag
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    if (!w) exq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (cpu_stall === 1'b1) stall_cyc <= stall_cyc + 1;
    if (flash_low_prio === 1'b1 && flash_req === 1'b1) low_cyc <= low_cyc + 1;
  end
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = exq.pop_front();
      if (nt[33]) chk({pslverr, prdata}, nt[32:0]);
    end
  end
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 34'h0);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 32'h0, {10'h200, 16'h0, d});
  endtask
  task poll(input logic b);
    do apb(1'b0, FCS_OFF_STATUS, 32'h0, 34'h0); while (rdv[0] !== b);
  endtask
  function automatic logic [15:0] crc(input int n);
    logic [15:0] c;
    c = FCS_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      for (int b = 15; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ fcs_flash_model_i.mem[i][b]) ? FCS_CRC_POLY : 16'h0);
      end
    end
    return c;
  endfunction
  task scan(input logic [1:0] m, s, input logic [7:0] stop, input logic bad, ie);
    int n;
    logic [7:0] cf;
    int s0, l0;
    n = (s == 2'h0) ? 8 : (s == 2'h1) ? 6 : 4;
    cf = {2'b00, m, 2'b00, s};
    for (int i = 0; i < n - 1; i++) begin
      fcs_flash_model_i.mem[i] = 16'($urandom);
    end
    fcs_flash_model_i.mem[n - 1] = crc(n - 1);
    fcs_flash_model_i.mem[0][3] ^= bad;
    if (ie) wr(FCS_OFF_CONTROL, 8'h02);
    wr(FCS_OFF_CONFIG, cf);
    s0 = stall_cyc;
    l0 = low_cyc;
    wr(FCS_OFF_CONTROL, {6'h00, ie, 1'b1});
    if (m == 2'h1 || s == 2'h3) begin
      rd(FCS_OFF_STATUS, 8'h00);
    end else begin
      rd(FCS_OFF_STATUS, 8'h01);
      wr(FCS_OFF_CONFIG, 8'h33);
      // Repeat mode runs on until software stops it or a check fails
      if (m == 2'h3) wr(FCS_OFF_CONTROL, stop);
      else wr(FCS_OFF_CONTROL, 8'h03);
      poll(1'b0);
      rd(FCS_OFF_CONFIG, stop[7] ? 8'h00 : cf);
      rd(FCS_OFF_STATUS, (bad || stop[7]) ? 8'h00 : 8'h02);
      rd(FCS_OFF_CONTROL, {6'h00, ie, !(bad || m == 2'h3)});
      chk({32'h0, stall_cyc != s0}, {32'h0, m == 2'h0});
      chk({32'h0, low_cyc != l0}, {32'h0, m != 2'h0});
    end
    $display("scan mode=%0d section=%0d done", m, s);
  endtask
  ////////////////////////////////
  initial begin
    void'($urandom(32'h38BDD572));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(FCS_OFF_CONTROL, 8'h00);
    rd(FCS_OFF_CONFIG, 8'h00);
    wr(FCS_OFF_STATUS, 8'h01);
    rd(FCS_OFF_STATUS, 8'h02);
    apb(1'b0, 12'h0FC, 32'h0, 34'h3_0000_0000);
    // Small sections keep each pass short
    wr(FCS_OFF_FLASH_WORDS, 8'h08);
    wr(FCS_OFF_BOOT_APP_WORDS, 8'h06);
    wr(FCS_OFF_BOOT_WORDS, 8'h04);
    $display("register test done");
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 3; s++) scan(md[k], 2'(s), 8'h00, 1'b0, 1'b0);
    end
    scan(2'h1, 2'h0, 8'h00, 1'b0, 1'b0);
    scan(2'h2, 2'h3, 8'h00, 1'b0, 1'b0);
    scan(2'h3, 2'h1, 8'h80, 1'b0, 1'b0);
    scan(2'h0, 2'h2, 8'h00, 1'b1, 1'b1);
    chk({32'h0, fail_nmi}, 33'h1);
    wr(FCS_OFF_CONTROL, 8'h81);
    rd(FCS_OFF_CONTROL, 8'h02);
    wr(FCS_OFF_CONFIG, 8'h20);
    rd(FCS_OFF_CONFIG, 8'h02);
    $display("failure test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({32'h0, fail_nmi}, 33'h0);
    wr(FCS_OFF_BOOT_WORDS, 8'h04);
    fcs_flash_model_i.mem[0][3] ^= 1'b1;
    boot_scan_setup <= '{mode: 2'h0, section: FCS_SECT_BOOT};
    boot_scan_req <= 1'b1;
    poll(1'b1);
    poll(1'b0);
    rd(FCS_OFF_CONTROL, 8'h01);
    rd(FCS_OFF_CONFIG, 8'h22);
    rd(FCS_OFF_STATUS, 8'h02);
    $display("startup test done");
    summarize;
  end
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    summarize;
  end
endmodule // fcs_scan_control_tb
bind fcs_scan_control fcs_scan_control_assertions #(.ADDR_W(ADDR_W)) fcs_scan_control_assertions_i (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .cpu_stall,
  .flash_req, .flash_low_prio, .flash_addr, .flash_gnt, .fail_nmi);
